//--- hw/imascr_consts.svh
`ifndef IMASCR_CONSTS_SVH
`define IMASCR_CONSTS_SVH

// Register indices; byte address is four times the index
`define IMASCR_IDX_VER1 11'h400
`define IMASCR_IDX_VER2 11'h401
`define IMASCR_IDX_CFG 11'h402
`define IMASCR_IDX_STAT 11'h403
`define IMASCR_IDX_W 11
`define IMASCR_BYTE_SHIFT 2

// Configuration field positions and reset
`define IMASCR_CFG_RESET 8'h00
`define IMASCR_CFG_LINK_HI 7
`define IMASCR_CFG_LINK_LO 6
`define IMASCR_CFG_SRAM_HI 5
`define IMASCR_CFG_SRAM_LO 4
`define IMASCR_CFG_NSRAM 3
`define IMASCR_CFG_PORT_HI 2
`define IMASCR_CFG_PORT_LO 0

// PHY address limit: port count above two low ones
`define IMASCR_LIMIT_ONES 2'h3
`define IMASCR_LIMIT_RESET 5'h03

// Status bit positions
`define IMASCR_ST_TXA4 7
`define IMASCR_ST_RXA4 6
`define IMASCR_ST_WIDTH 4
`define IMASCR_ST_REFCLK 3
`define IMASCR_ST_TXPAR 2
`define IMASCR_ST_RXPAR 0

// Identification fields
`define IMASCR_ID_MEMBIT 3
`define IMASCR_ID_MEM_PRESENT 1'h1

// Delay buffer depths in milliseconds per size code
`define IMASCR_DEPTH_0 8'h19
`define IMASCR_DEPTH_1 8'h32
`define IMASCR_DEPTH_2 8'h64
`define IMASCR_DEPTH_3 8'hC8

// Reference clock activity window
`define IMASCR_CLK_PERIOD_NS 10
`define IMASCR_REFCLK_TIMEOUT_NS 2000
`define IMASCR_REFCLK_TIMEOUT_CYC \
  ((`IMASCR_REFCLK_TIMEOUT_NS + `IMASCR_CLK_PERIOD_NS - 1) / \
   `IMASCR_CLK_PERIOD_NS)

`endif

//--- hw/imascr_pkg.sv
package imascr_pkg;

  typedef logic [7:0] imascr_byte_t;
  typedef logic [1:0] imascr_link_t;

  // Bus slave state
  typedef struct packed {
    logic ready;
    logic [31:0] rdata;
    logic slvErr;
  } imascr_apb_st_t;

  // Reference clock monitor state
  typedef struct packed {
    logic lastLevel;
    logic [15:0] idleCount;
    logic fault;
  } imascr_mon_st_t;

  // Register bank state
  typedef struct packed {
    logic [7:0] cfg;
    logic refClkErr;
    logic txParErr;
    logic rxParErr;
    logic [7:0] delayMs;
    logic [4:0] phyAddrLimit;
    logic phyAddrOk;
  } imascr_regs_st_t;

endpackage : imascr_pkg

//--- hw/imascr_reg_if.sv
`timescale 1ns/10ps
`default_nettype none

// Access strobes between the bus slave and the register bank
interface imascr_reg_if #(parameter int AW = 16);
  logic commit;
  logic isWrite;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic wlane;
  logic [7:0] rdata;
  logic hit;
  logic [7:0] shown;

  modport slave (output commit, isWrite, addr, wdata, wlane, shown,
                 input rdata, hit);
  modport regs (input commit, isWrite, addr, wdata, wlane, shown,
                output rdata, hit);
endinterface : imascr_reg_if

`default_nettype wire

//--- hw/imascr_apb_slave.sv
`timescale 1ns/10ps
`default_nettype none

module imascr_apb_slave #(
  parameter int AW = 16
) (
  input wire logic core_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  imascr_reg_if.slave bus // To register bank
);
  import imascr_pkg::*;

  imascr_apb_st_t st;
  imascr_apb_st_t next_st;

  // Request fields pass straight through; commit only on the ready edge
  assign bus.commit = psel & penable & st.ready;
  assign bus.isWrite = pwrite;
  assign bus.addr = paddr;
  assign bus.wdata = pwdata[7:0];
  assign bus.wlane = pstrb[0];
  assign bus.shown = st.rdata[7:0];
  assign pready = st.ready;
  assign prdata = st.rdata;
  assign pslverr = st.slvErr;

  // One wait state: data captured, then answered on the next edge
  always_comb begin
    next_st = st;
    next_st.ready = psel & penable & ~st.ready;
    if (psel & penable & ~st.ready) begin
      next_st.slvErr = ~bus.hit;
      next_st.rdata = (bus.hit & ~pwrite) ? {24'h000000, bus.rdata}
                                          : 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : imascr_apb_slave

`default_nettype wire

//--- hw/imascr_refclk_mon.sv
`timescale 1ns/10ps
`default_nettype none
`include "imascr_consts.svh"

module imascr_refclk_mon #(
  parameter int TIMEOUT = `IMASCR_REFCLK_TIMEOUT_CYC
) (
  input wire logic core_clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic refLevel, // Sampled reference clock level
  output logic fault // One-cycle pulse on a dead window
);
  import imascr_pkg::*;

  imascr_mon_st_t st;
  imascr_mon_st_t next_st;

  assign fault = st.fault;

  // A stuck input pulses once per window, so a read-cleared flag re-arms
  always_comb begin
    next_st = st;
    next_st.lastLevel = refLevel;
    next_st.fault = 1'b0;
    if (refLevel != st.lastLevel) begin
      next_st.idleCount = 16'h0000;
    end else if (st.idleCount == 16'(TIMEOUT - 1)) begin
      next_st.idleCount = 16'h0000;
      next_st.fault = 1'b1;
    end else begin
      next_st.idleCount = st.idleCount + 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : imascr_refclk_mon

`default_nettype wire

//--- hw/imascr_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "imascr_consts.svh"

module imascr_top #(
  parameter int AW = 16,
  parameter logic [3:0] CORE_TYPE = 4'h1, // Arbitrary value
  parameter logic [2:0] MAJOR_VER = 3'h5, // Arbitrary value
  parameter logic [3:0] VER_CODE2 = 4'h6, // Arbitrary value
  parameter logic [3:0] VER_CODE3 = 4'h7, // Arbitrary value
  parameter int REFCLK_TIMEOUT = `IMASCR_REFCLK_TIMEOUT_CYC
) (
  input wire logic core_clk, // System clock, 100 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB byte strobes
  output logic pready, // APB ready
  output logic [31:0] prdata, // APB read data
  output logic pslverr, // APB error
  input wire logic reference_clock_in, // Reference clock, sampled
  input wire logic atm_tx_address_bit4, // Tx ATM address bit 4
  input wire logic atm_rx_address_bit4, // Rx ATM address bit 4
  input wire logic atmBusWide, // High when ATM bus is 16-bit
  input wire logic txAtmParityErr, // Tx ATM parity error pulse
  input wire logic rxPhyParityErr, // Rx PHY parity error pulse
  input wire logic [4:0] phyAddrProbe, // PHY address to qualify
  output imascr_pkg::imascr_link_t defaultLinkType, // Link type code
  output logic [1:0] sramSizeCode, // Delay SRAM size code
  output logic sramCount, // SRAM count bit
  output logic [2:0] portCount, // Port count field
  output logic [7:0] delayDepthMs, // Delay buffer depth, ms
  output logic [4:0] phyAddrLimit, // Highest valid PHY address
  output logic phyAddrValid // Probe address within range
);
  import imascr_pkg::*;

  imascr_reg_if #(.AW(AW)) bus ();

  imascr_regs_st_t st;
  imascr_regs_st_t next_st;
  logic refFault;
  logic [AW-1:0] idxFull;
  logic [`IMASCR_IDX_W-1:0] idx;
  logic aligned;
  logic inRange;
  logic [7:0] statusByte;
  logic [7:0] readByte;
  logic cfgWrite;
  logic statRead;

  // Bus handshake lives in its own slave
  imascr_apb_slave #(.AW(AW)) u_apb (
    .core_clk(core_clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .bus(bus)
  );

  // Activity detector on the reference clock
  imascr_refclk_mon #(.TIMEOUT(REFCLK_TIMEOUT)) u_mon (
    .core_clk(core_clk),
    .rstn(rstn),
    .refLevel(reference_clock_in),
    .fault(refFault)
  );

  // Address decode: word aligned, index inside the four-register window
  assign idxFull = bus.addr >> `IMASCR_BYTE_SHIFT;
  assign idx = idxFull[`IMASCR_IDX_W-1:0];
  assign aligned = (bus.addr[1:0] == 2'h0);
  assign inRange = (idxFull == AW'(`IMASCR_IDX_VER1)) ||
                   (idxFull == AW'(`IMASCR_IDX_VER2)) ||
                   (idxFull == AW'(`IMASCR_IDX_CFG)) ||
                   (idxFull == AW'(`IMASCR_IDX_STAT));
  assign bus.hit = aligned & inRange;

  // Status byte; address and width bits follow the pins live
  always_comb begin
    statusByte = 8'h00;
    statusByte[`IMASCR_ST_TXA4] = atm_tx_address_bit4;
    statusByte[`IMASCR_ST_RXA4] = atm_rx_address_bit4;
    statusByte[`IMASCR_ST_WIDTH] = atmBusWide;
    statusByte[`IMASCR_ST_REFCLK] = st.refClkErr;
    statusByte[`IMASCR_ST_TXPAR] = st.txParErr;
    statusByte[`IMASCR_ST_RXPAR] = st.rxParErr;
  end

  // Read mux; the slave captures it one cycle before answering
  always_comb begin
    case (idx)
      `IMASCR_IDX_VER1: begin
        readByte = {CORE_TYPE, `IMASCR_ID_MEM_PRESENT,
                    MAJOR_VER};
      end
      `IMASCR_IDX_VER2: begin
        readByte = {VER_CODE2, VER_CODE3};
      end
      `IMASCR_IDX_CFG: begin
        readByte = st.cfg;
      end
      `IMASCR_IDX_STAT: begin
        readByte = statusByte;
      end
      default: begin
        readByte = 8'h00;
      end
    endcase
  end
  assign bus.rdata = readByte;

  // Only the configuration register accepts writes, lane 0 only
  assign cfgWrite = bus.commit & bus.isWrite & bus.hit & bus.wlane &
                    (idx == `IMASCR_IDX_CFG);
  assign statRead = bus.commit & ~bus.isWrite & bus.hit &
                    (idx == `IMASCR_IDX_STAT);

  // Register bank update
  always_comb begin
    next_st = st;
    if (cfgWrite) begin
      // Port count and SRAM count are stored as written; keeping them
      // legal on small variants is software's job
      next_st.cfg = bus.wdata;
    end
    // Read clears only the bits the reader saw; a new event wins
    if (statRead) begin
      next_st.refClkErr = st.refClkErr & ~bus.shown[`IMASCR_ST_REFCLK];
      next_st.txParErr = st.txParErr & ~bus.shown[`IMASCR_ST_TXPAR];
      next_st.rxParErr = st.rxParErr & ~bus.shown[`IMASCR_ST_RXPAR];
    end
    if (refFault) begin
      next_st.refClkErr = 1'b1;
    end
    if (txAtmParityErr) begin
      next_st.txParErr = 1'b1;
    end
    if (rxPhyParityErr) begin
      next_st.rxParErr = 1'b1;
    end
    // Buffer depth from size code, tracks the stored field
    case (st.cfg[`IMASCR_CFG_SRAM_HI:`IMASCR_CFG_SRAM_LO])
      2'h0: next_st.delayMs = `IMASCR_DEPTH_0;
      2'h1: next_st.delayMs = `IMASCR_DEPTH_1;
      2'h2: next_st.delayMs = `IMASCR_DEPTH_2;
      2'h3: next_st.delayMs = `IMASCR_DEPTH_3;
      default: next_st.delayMs = `IMASCR_DEPTH_0;
    endcase
    // Limit is 4(n+1)-1, i.e. n in the top bits and ones below
    next_st.phyAddrLimit = {st.cfg[`IMASCR_CFG_PORT_HI:`IMASCR_CFG_PORT_LO],
                            `IMASCR_LIMIT_ONES};
    next_st.phyAddrOk = (phyAddrProbe <= st.phyAddrLimit);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st.cfg <= `IMASCR_CFG_RESET;
      st.refClkErr <= 1'b0;
      st.txParErr <= 1'b0;
      st.rxParErr <= 1'b0;
      st.delayMs <= `IMASCR_DEPTH_0;
      st.phyAddrLimit <= `IMASCR_LIMIT_RESET;
      st.phyAddrOk <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Configuration fields leave straight from the register
  assign defaultLinkType =
    st.cfg[`IMASCR_CFG_LINK_HI:`IMASCR_CFG_LINK_LO];
  assign sramSizeCode = st.cfg[`IMASCR_CFG_SRAM_HI:`IMASCR_CFG_SRAM_LO];
  assign sramCount = st.cfg[`IMASCR_CFG_NSRAM];
  assign portCount = st.cfg[`IMASCR_CFG_PORT_HI:`IMASCR_CFG_PORT_LO];
  assign delayDepthMs = st.delayMs;
  assign phyAddrLimit = st.phyAddrLimit;
  assign phyAddrValid = st.phyAddrOk;
endmodule : imascr_top

`default_nettype wire

//--- tb/imascr_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module imascr_top_monitor (
  input wire logic core_clk, // Clock
  input wire logic rstn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Direction
  input wire logic [15:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Strobes
  input wire logic pready, // Ready
  input wire logic [31:0] prdata, // Read data
  input wire logic atm_tx_address_bit4, // Tx bit 4
  input wire logic atm_rx_address_bit4, // Rx bit 4
  input wire logic atmBusWide, // Bus width
  input wire logic txAtmParityErr, // Tx parity
  input wire imascr_pkg::imascr_link_t defaultLinkType, // Link type
  input wire logic [1:0] sramSizeCode, // Size code
  input wire logic [2:0] portCount, // Port count
  input wire logic [7:0] delayDepthMs, // Depth
  input wire logic [4:0] phyAddrLimit // Address limit
);
  import imascr_pkg::*;
  logic done;
  logic rdSt;
  // Completed transfer, and completed status read
  assign done = psel && penable && pready;
  assign rdSt = done && !pwrite && paddr == 16'h100C;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_id;
    done && !pwrite && paddr == 16'h1000 |-> prdata[3] && !prdata[31:8];
  endproperty
  a_id: assert property (p_id) else $error("id bit wrong");
  // Status captured one edge before ready
  property p_live;
    rdSt |-> prdata[7] == $past(atm_tx_address_bit4) &&
      prdata[6] == $past(atm_rx_address_bit4);
  endproperty
  a_live: assert property (p_live) else $error("live bits");
  property p_width;
    rdSt |-> prdata[4] == $past(atmBusWide);
  endproperty
  a_width: assert property (p_width) else $error("width bit");
  property p_resv;
    rdSt |-> !prdata[5] && !prdata[1] && !prdata[31:8];
  endproperty
  a_resv: assert property (p_resv) else $error("reserved set");
  property p_txpar;
    rdSt && $past(txAtmParityErr, 2) |-> prdata[2];
  endproperty
  a_txpar: assert property (p_txpar) else $error("tx parity lost");
  property p_link;
    done && pwrite && paddr == 16'h1008 && pstrb[0] |=>
      defaultLinkType == $past(pwdata[7:6]) &&
      sramSizeCode == $past(pwdata[5:4]);
  endproperty
  a_link: assert property (p_link) else $error("cfg not taken");
  // Depth and limit lag the config by one edge
  property p_depth;
    delayDepthMs == 8'h19 << $past(sramSizeCode);
  endproperty
  a_depth: assert property (p_depth) else $error("depth wrong");
  property p_limit;
    phyAddrLimit == {$past(portCount), 2'b11};
  endproperty
  a_limit: assert property (p_limit) else $error("limit wrong");
  c_tx: cover property (rdSt && prdata[2]);
  c_ref: cover property (rdSt && prdata[3]);
  c_wr: cover property (done && pwrite);
endmodule : imascr_top_monitor

bind imascr_top imascr_top_monitor u_chk (
  .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata),
  .atm_tx_address_bit4(atm_tx_address_bit4),
  .atm_rx_address_bit4(atm_rx_address_bit4), .atmBusWide(atmBusWide),
  .txAtmParityErr(txAtmParityErr), .defaultLinkType(defaultLinkType),
  .sramSizeCode(sramSizeCode), .portCount(portCount),
  .delayDepthMs(delayDepthMs), .phyAddrLimit(phyAddrLimit)
);
`default_nettype wire

//--- tb/ima_subsystem_common_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ima_subsystem_common_regs_bench;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic refClk = 1'b0;
  logic refRun = 1'b1;
  logic txA4 = 1'b0;
  logic rxA4 = 1'b0;
  logic wide = 1'b0;
  logic txPe = 1'b0;
  logic rxPe = 1'b0;
  logic [4:0] probe = 5'h00;
  logic pready, pslverr, nsram, valid;
  logic [31:0] prdata;
  imascr_pkg::imascr_link_t link;
  logic [1:0] size;
  logic [2:0] ports;
  logic [7:0] depth;
  logic [4:0] limit;
  logic [33:0] expQ[$];
  logic [33:0] e;
  int err_count = 0;
  int tests_run = 0;
  int cyc = 0;

  imascr_top #(.REFCLK_TIMEOUT(8)) dut (
    .core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reference_clock_in(refClk), .atm_tx_address_bit4(txA4),
    .atm_rx_address_bit4(rxA4), .atmBusWide(wide),
    .txAtmParityErr(txPe), .rxPhyParityErr(rxPe), .phyAddrProbe(probe),
    .defaultLinkType(link), .sramSizeCode(size), .sramCount(nsram),
    .portCount(ports), .delayDepthMs(depth), .phyAddrLimit(limit),
    .phyAddrValid(valid));

  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task check(input string nm, input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  // One APB transfer; x holds {check data, error, data}
  task xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
    input logic [33:0] x);
    expQ.push_back(x);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Request stands until pready is sampled high at a rising edge
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task rd(input logic [15:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0, {2'b10, x});
  endtask : rd

  // Expected status from live inputs plus sticky flags
  function automatic logic [31:0] st(input logic [3:0] f);
    return {24'h0, txA4, rxA4, 1'b0, wide, f};
  endfunction : st

  always #5 core_clk = ~core_clk;

  // Keeps the reference clock alive unless a test stops it
  always @(posedge core_clk) begin
    if (refRun) refClk <= ~refClk;
  end

  // Answers are checked where pready has settled
  always @(negedge core_clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (expQ.size() == 0) check("queue", 32'h1, 32'h0);
      else begin
        e = expQ.pop_front();
        check("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
        if (e[33]) check("prdata", prdata, e[31:0]);
      end
    end
  end

  // Hang guard, far above the expected run length
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      report_and_stop;
    end
  end

  initial begin
    logic [7:0] c;
    void'($urandom(44));
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(16'h1000, 32'h1D);
    rd(16'h1004, 32'h67);
    rd(16'h1008, 32'h00);
    xfer(1'b1, 16'h1000, 32'hFF, 34'h0);
    xfer(1'b1, 16'h100C, 32'hFF, 34'h0);
    rd(16'h1000, 32'h1D);
    rd(16'h100C, st(4'h0));
    // Every link and size code, random port count and live inputs
    for (int i = 0; i < 4; i++) begin
      c = {i[1:0], i[1:0], 1'b0, 3'($urandom_range(7))};
      probe <= 5'($urandom);
      {txA4, rxA4, wide} <= 3'($urandom);
      xfer(1'b1, 16'h1008, {24'h0, c}, 34'h0);
      repeat (3) @(posedge core_clk);
      check("link", 32'(link), 32'(i[1:0]));
      check("size", 32'(size), 32'(i[1:0]));
      check("ports", 32'(ports), 32'(c[2:0]));
      check("depth", 32'(depth), 32'(25 << i));
      check("limit", 32'(limit), 32'({c[2:0], 2'b11}));
      check("valid", 32'(valid), 32'(probe <= {c[2:0], 2'b11}));
      check("nsram", 32'(nsram), 32'h0);
      rd(16'h1008, {24'h0, c});
      rd(16'h100C, st(4'h0));
    end
    // Parity pulses latch, then one read clears them
    for (int j = 0; j < 2; j++) begin
      @(posedge core_clk);
      {txPe, rxPe} <= j ? 2'b01 : 2'b10;
      @(posedge core_clk);
      {txPe, rxPe} <= 2'b00;
      rd(16'h100C, st(j ? 4'h1 : 4'h4));
      rd(16'h100C, st(4'h0));
    end
    // Parity pulse lands on the setup edge of a status read
    fork
      rd(16'h100C, st(4'h4));
      begin
        @(posedge core_clk);
        txPe <= 1'b1;
        @(posedge core_clk);
        txPe <= 1'b0;
      end
    join
    refRun <= 1'b0;
    repeat (12) @(posedge core_clk);
    rd(16'h100C, st(4'h8));
    refRun <= 1'b1;
    xfer(1'b0, 16'h100C, 32'h0, 34'h0);
    rd(16'h100C, st(4'h0));
    // Unmapped and unaligned places are refused
    xfer(1'b0, 16'h1010, 32'h0, {2'b11, 32'h0});
    xfer(1'b1, 16'h1009, 32'hFF, {2'b01, 32'h0});
    rd(16'h1008, {24'h0, c});
    // Lane 0 strobe low: the write is dropped without an error
    pstrb <= 4'hE;
    xfer(1'b1, 16'h1008, 32'h00, 34'h0);
    pstrb <= 4'hF;
    rd(16'h1008, {24'h0, c});
    // Mid-run reset returns the bank to its reset values
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    check("rstdepth", 32'(depth), 32'h19);
    check("rstlimit", 32'(limit), 32'h03);
    rd(16'h1008, 32'h00);
    report_and_stop;
  end
endmodule : ima_subsystem_common_regs_bench
`default_nettype wire
